// ---- src/rtc_pkg.sv ----
// Constants, register map and field layout of the real-time counter block.
// Assumes a 20 MHz system clock and a 32.768 kHz crystal clock arriving as a plain pin.
package rtc_pkg;

   // Bus and counter widths
   localparam int unsigned RTC_ADR_W = 32;
   localparam int unsigned RTC_DAT_W = 32;
   localparam int unsigned RTC_SEL_W = 4;
   localparam int unsigned RTC_CNT_W = 18;
   localparam int unsigned RTC_CTL_W = 8;
   localparam int unsigned RTC_EV_W = 4;
   localparam int unsigned RTC_SEC_W = 14;

   // Register byte addresses
   localparam logic [31:0] RTC_CONTROL_STATUS_ADR = 32'h0500_0060;
   localparam logic [31:0] RTC_RUNNING_COUNT_ADR = 32'h0500_0064;
   localparam logic [31:0] RTC_FIRST_ALARM_ADR = 32'h0500_0068;
   localparam logic [31:0] RTC_SECOND_ALARM_ADR = 32'h0500_006C;
   localparam logic [31:0] RTC_EVENT_STATUS_ADR = 32'h0500_0080;
   localparam logic [31:0] RTC_EVENT_CLEAR_ADR = 32'h0500_0084;
   localparam logic [31:0] RTC_EVENT_ENABLE_ADR = 32'h0500_0088;

   // Decoded register selector
   localparam logic [2:0] RTC_REG_NONE = 3'h0;
   localparam logic [2:0] RTC_REG_CTL = 3'h1;
   localparam logic [2:0] RTC_REG_CNT = 3'h2;
   localparam logic [2:0] RTC_REG_ALM1 = 3'h3;
   localparam logic [2:0] RTC_REG_ALM2 = 3'h4;
   localparam logic [2:0] RTC_REG_EVST = 3'h5;
   localparam logic [2:0] RTC_REG_EVCLR = 3'h6;
   localparam logic [2:0] RTC_REG_EVEN = 3'h7;

   // Control register fields
   localparam int unsigned RTC_EN_BIT = 0;
   localparam int unsigned RTC_LOCK_BIT = 1;
   localparam int unsigned RTC_OVF_IE_BIT = 2;
   localparam int unsigned RTC_ALARM_IE_BIT = 3;
   localparam int unsigned RTC_OVF_FLAG_BIT = 4;
   localparam int unsigned RTC_SECOND_FLAG_BIT = 5;
   localparam int unsigned RTC_FIRST_FLAG_BIT = 6;
   localparam logic [7:0] RTC_CTL_RESET = 8'h0D;

   // Event status fields
   localparam int unsigned RTC_EV_FIRST_ALARM = 0;
   localparam int unsigned RTC_EV_SECOND_ALARM = 1;
   localparam int unsigned RTC_EV_OVERFLOW = 2;
   localparam int unsigned RTC_EV_SECOND_TICK = 3;

   // Timing
   localparam int unsigned RTC_XTAL_HZ = 32768;
   localparam int unsigned RTC_TICK_DIV = 2;
   localparam int unsigned RTC_TICK_HZ = RTC_XTAL_HZ / RTC_TICK_DIV;
   localparam logic [13:0] RTC_SEC_LAST = 14'(RTC_TICK_HZ - 1);
   localparam logic [17:0] RTC_CNT_MAX = 18'h3FFFF;

endpackage

// ---- src/rtc_counter_top.sv ----
// Real-time counter with two alarms, overflow flag, lock and event interrupts on classic Wishbone.
// Assumes clk_i is the 20 MHz system clock and xtal_i the asynchronous 32.768 kHz crystal clock.
//
// Summary of operation
// - Count advances on crystal clock halved to 16.384 kHz, sampled and stepped in the bus clock domain.
// - Separate alarm and overflow interrupt requests; either one asserts wake.
// - Count reads always return a consistent value while counting.
// - Configuration writes other than the lock bit and event enable are dropped while lock is set; effective once lock cleared.
// - Lock is control bit 1; 0 allows configuration writes, 1 blocks them.
// - Counter enable is control bit 0; 0 stops counting, 1 runs it.
// - Alarm interrupt enable is control bit 3; 0 masks alarm request.
// - Overflow interrupt enable is control bit 2; 0 masks overflow request.
// - Overflow flag is control bit 4, inverted: 0 means overflow occurred.
// - First alarm flag is control bit 6, set on match with first alarm.
// - Second alarm flag is control bit 5, set on match with second alarm.
// - Count register holds writable 18-bit count in bits 17..0, upper bits zero.
// - First alarm register holds 18-bit compare value in bits 17..0.
// - Second alarm register holds 18-bit compare value in bits 17..0.
// - A once-per-second tick goes to firmware; calendar is kept in software.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps
module rtc_counter_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [rtc_pkg::RTC_ADR_W-1:0] adr_i,
   input wire logic [rtc_pkg::RTC_SEL_W-1:0] sel_i,
   input wire logic [rtc_pkg::RTC_DAT_W-1:0] dat_i,
   output logic [rtc_pkg::RTC_DAT_W-1:0] dat_o,
   output logic ack_o,
   // Crystal clock pin
   input wire logic xtal_i,
   // Interrupts and tick
   output logic alarm_irq_o,
   output logic overflow_irq_o,
   output logic wake_o,
   output logic irq_o,
   output logic second_tick_o
);
   import rtc_pkg::*;

   function automatic logic [2:0] rtc_decode(input logic [RTC_ADR_W-1:0] adr);
      logic [2:0] r;
      r = RTC_REG_NONE;
      if (adr == RTC_CONTROL_STATUS_ADR) begin
         r = RTC_REG_CTL;
      end else if (adr == RTC_RUNNING_COUNT_ADR) begin
         r = RTC_REG_CNT;
      end else if (adr == RTC_FIRST_ALARM_ADR) begin
         r = RTC_REG_ALM1;
      end else if (adr == RTC_SECOND_ALARM_ADR) begin
         r = RTC_REG_ALM2;
      end else if (adr == RTC_EVENT_STATUS_ADR) begin
         r = RTC_REG_EVST;
      end else if (adr == RTC_EVENT_CLEAR_ADR) begin
         r = RTC_REG_EVCLR;
      end else if (adr == RTC_EVENT_ENABLE_ADR) begin
         r = RTC_REG_EVEN;
      end
      return r;
   endfunction

   // Byte-lane merge of a write into an old word
   function automatic logic [RTC_DAT_W-1:0] rtc_merge(input logic [RTC_DAT_W-1:0] old_v,
                                                      input logic [RTC_DAT_W-1:0] new_v,
                                                      input logic [RTC_SEL_W-1:0] sel);
      logic [RTC_DAT_W-1:0] r;
      r = old_v;
      for (int i = 0; i < RTC_SEL_W; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   logic xtal_meta_r;
   logic xtal_sync_r;
   logic xtal_prev_r;
   logic half_r;
   logic tick;
   logic en_r;
   logic lock_r;
   logic ovf_ie_r;
   logic alarm_ie_r;
   logic ovf_flag_r;
   logic first_alarm_flag_r;
   logic second_alarm_flag_r;
   logic [RTC_CNT_W-1:0] cnt_r;
   logic [RTC_CNT_W-1:0] cnt_nxt;
   logic [RTC_CNT_W-1:0] first_compare_value_r;
   logic [RTC_CNT_W-1:0] second_compare_value_r;
   logic [RTC_SEC_W-1:0] sec_cnt_r;
   logic [RTC_EV_W-1:0] ev_status_r;
   logic [RTC_EV_W-1:0] ev_enable_r;
   logic [RTC_EV_W-1:0] ev_set;
   logic req;
   logic wr;
   logic [2:0] reg_sel;
   logic [RTC_DAT_W-1:0] ctl_word;
   logic [RTC_DAT_W-1:0] ctl_wdat;
   logic [RTC_DAT_W-1:0] cnt_wdat;
   logic [RTC_DAT_W-1:0] alm1_wdat;
   logic [RTC_DAT_W-1:0] alm2_wdat;
   logic [RTC_DAT_W-1:0] even_wdat;
   logic [RTC_DAT_W-1:0] rd_word;
   logic cfg_wr_ok;
   logic ctl_clr;
   logic count_step;
   logic first_hit;
   logic second_hit;
   logic wrap_hit;
   logic second_hit_1hz;

   // Crystal pin: two flops before any logic looks at it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xtal_meta_r <= 1'b0;
         xtal_sync_r <= 1'b0;
         xtal_prev_r <= 1'b0;
      end else begin
         xtal_meta_r <= xtal_i;
         xtal_sync_r <= xtal_meta_r;
         xtal_prev_r <= xtal_sync_r;
      end
   end

   // Every second crystal rising edge makes one 16.384 kHz tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         half_r <= 1'b0;
      end else if (xtal_sync_r && !xtal_prev_r) begin
         half_r <= ~half_r;
      end
   end
   assign tick = xtal_sync_r && !xtal_prev_r && half_r;

   // Bus decode; the write lands at the edge where the master sees ack
   assign req = cyc_i && stb_i;
   assign reg_sel = rtc_decode(adr_i);
   assign wr = req && we_i && ack_o;
   assign cfg_wr_ok = wr && !lock_r;
   // Flag clears need byte 0 itself, or a merged read-back of a set flag would clear it
   assign ctl_clr = wr && reg_sel == RTC_REG_CTL && sel_i[0];

   assign ctl_word = {24'h000000, 1'b0, first_alarm_flag_r, second_alarm_flag_r, ~ovf_flag_r,
                      alarm_ie_r, ovf_ie_r, lock_r, en_r};
   assign ctl_wdat = rtc_merge(ctl_word, dat_i, sel_i);
   assign cnt_wdat = rtc_merge({14'h0000, cnt_r}, dat_i, sel_i);
   assign alm1_wdat = rtc_merge({14'h0000, first_compare_value_r}, dat_i, sel_i);
   assign alm2_wdat = rtc_merge({14'h0000, second_compare_value_r}, dat_i, sel_i);
   assign even_wdat = rtc_merge({28'h0000000, ev_enable_r}, dat_i, sel_i);

   // Lock stays writable so software can leave it; enables only while unlocked
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_r <= RTC_CTL_RESET[RTC_EN_BIT];
         lock_r <= RTC_CTL_RESET[RTC_LOCK_BIT];
         ovf_ie_r <= RTC_CTL_RESET[RTC_OVF_IE_BIT];
         alarm_ie_r <= RTC_CTL_RESET[RTC_ALARM_IE_BIT];
      end else if (wr && reg_sel == RTC_REG_CTL) begin
         lock_r <= ctl_wdat[RTC_LOCK_BIT];
         if (!lock_r) begin
            en_r <= ctl_wdat[RTC_EN_BIT];
            ovf_ie_r <= ctl_wdat[RTC_OVF_IE_BIT];
            alarm_ie_r <= ctl_wdat[RTC_ALARM_IE_BIT];
         end
      end
   end

   // Counter
   assign count_step = en_r && tick;
   assign cnt_nxt = cnt_r + 18'h00001;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else if (cfg_wr_ok && reg_sel == RTC_REG_CNT) begin
         cnt_r <= cnt_wdat[RTC_CNT_W-1:0];
      end else if (count_step) begin
         cnt_r <= cnt_nxt;
      end
   end

   // Alarm compare values
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_compare_value_r <= '0;
         second_compare_value_r <= '0;
      end else if (cfg_wr_ok) begin
         if (reg_sel == RTC_REG_ALM1) begin
            first_compare_value_r <= alm1_wdat[RTC_CNT_W-1:0];
         end
         if (reg_sel == RTC_REG_ALM2) begin
            second_compare_value_r <= alm2_wdat[RTC_CNT_W-1:0];
         end
      end
   end

   // Matches are taken on the step that reaches the value, so a cleared flag is not re-set
   assign first_hit = count_step && cnt_nxt == first_compare_value_r;
   assign second_hit = count_step && cnt_nxt == second_compare_value_r;
   assign wrap_hit = count_step && cnt_r == RTC_CNT_MAX;

   // Sticky flags; writing 1 clears, a set in the same cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovf_flag_r <= 1'b0;
         first_alarm_flag_r <= 1'b0;
         second_alarm_flag_r <= 1'b0;
      end else begin
         ovf_flag_r <= wrap_hit ||
                       (ovf_flag_r && !(ctl_clr && dat_i[RTC_OVF_FLAG_BIT]));
         first_alarm_flag_r <= first_hit ||
                               (first_alarm_flag_r &&
                                !(ctl_clr && dat_i[RTC_FIRST_FLAG_BIT]));
         second_alarm_flag_r <= second_hit ||
                                (second_alarm_flag_r &&
                                 !(ctl_clr && dat_i[RTC_SECOND_FLAG_BIT]));
      end
   end

   // Once-per-second tick for the firmware calendar
   assign second_hit_1hz = count_step && sec_cnt_r == RTC_SEC_LAST;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sec_cnt_r <= '0;
         second_tick_o <= 1'b0;
      end else begin
         second_tick_o <= second_hit_1hz;
         if (second_hit_1hz) begin
            sec_cnt_r <= '0;
         end else if (count_step) begin
            sec_cnt_r <= sec_cnt_r + 14'h0001;
         end
      end
   end

   // Event status, clear and enable
   always_comb begin
      ev_set = '0;
      ev_set[RTC_EV_FIRST_ALARM] = first_hit;
      ev_set[RTC_EV_SECOND_ALARM] = second_hit;
      ev_set[RTC_EV_OVERFLOW] = wrap_hit;
      ev_set[RTC_EV_SECOND_TICK] = second_hit_1hz;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_status_r <= '0;
      end else if (wr && reg_sel == RTC_REG_EVCLR && sel_i[0]) begin
         ev_status_r <= ev_set | (ev_status_r & ~dat_i[RTC_EV_W-1:0]);
      end else begin
         ev_status_r <= ev_set | ev_status_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_enable_r <= '0;
      end else if (wr && reg_sel == RTC_REG_EVEN) begin
         ev_enable_r <= even_wdat[RTC_EV_W-1:0];
      end
   end

   // Interrupt outputs, registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alarm_irq_o <= 1'b0;
         overflow_irq_o <= 1'b0;
         wake_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         alarm_irq_o <= alarm_ie_r && (first_alarm_flag_r || second_alarm_flag_r);
         overflow_irq_o <= ovf_ie_r && ovf_flag_r;
         wake_o <= (alarm_ie_r && (first_alarm_flag_r || second_alarm_flag_r)) ||
                   (ovf_ie_r && ovf_flag_r);
         irq_o <= |(ev_status_r & ev_enable_r);
      end
   end

   // Read mux; one clock domain, so the count is never torn
   always_comb begin
      if (reg_sel == RTC_REG_CTL) begin
         rd_word = ctl_word;
      end else if (reg_sel == RTC_REG_CNT) begin
         rd_word = {14'h0000, cnt_r};
      end else if (reg_sel == RTC_REG_ALM1) begin
         rd_word = {14'h0000, first_compare_value_r};
      end else if (reg_sel == RTC_REG_ALM2) begin
         rd_word = {14'h0000, second_compare_value_r};
      end else if (reg_sel == RTC_REG_EVST) begin
         rd_word = {28'h0000000, ev_status_r};
      end else if (reg_sel == RTC_REG_EVEN) begin
         rd_word = {28'h0000000, ev_enable_r};
      end else begin
         rd_word = '0;
      end
   end

   // One wait state: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end else begin
         ack_o <= req && !ack_o;
         if (req && !ack_o && !we_i) begin
            dat_o <= rd_word;
         end
      end
   end

endmodule // rtc_counter_top

// ---- bench/rtc_counter_chk.sv ----
// Checker for bus handshake, interrupt, wake and tick outputs of the counter block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module rtc_counter_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [rtc_pkg::RTC_ADR_W-1:0] adr_i,
   input wire logic [rtc_pkg::RTC_SEL_W-1:0] sel_i,
   input wire logic [rtc_pkg::RTC_DAT_W-1:0] dat_i,
   input wire logic [rtc_pkg::RTC_DAT_W-1:0] dat_o,
   input wire logic ack_o,
   // Crystal, interrupts and tick
   input wire logic xtal_i,
   input wire logic alarm_irq_o,
   input wire logic overflow_irq_o,
   input wire logic wake_o,
   input wire logic irq_o,
   input wire logic second_tick_o
);
   import rtc_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence req_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence ack_pulse_s;
      ack_o ##1 !ack_o;
   endsequence
   ack_time_a: assert property (req_s |=> ack_pulse_s) else $error("ack not one cycle after request");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
   dat_hold_a: assert property (!(cyc_i && stb_i && !we_i && !ack_o) |=> $stable(dat_o))
      else $error("read data moved without a read");
   wake_src_a: assert property (wake_o |-> alarm_irq_o || overflow_irq_o || $past(alarm_irq_o || overflow_irq_o))
      else $error("wake without interrupt");
   wake_follow_a: assert property ((alarm_irq_o || overflow_irq_o) |-> ##[0:1] wake_o)
      else $error("interrupt without wake");
   // The request output lags the write by one cycle, so the write of the cycle before also excuses a drop
   alarm_keep_a: assert property (alarm_irq_o && !(cyc_i && stb_i && we_i) && !$past(cyc_i && stb_i && we_i)
      |=> alarm_irq_o) else $error("alarm request dropped without a write");
   ovf_keep_a: assert property (overflow_irq_o && !(cyc_i && stb_i && we_i) && !$past(cyc_i && stb_i && we_i)
      |=> overflow_irq_o) else $error("overflow request dropped without a write");
   tick_pulse_a: assert property (second_tick_o |=> !second_tick_o [*8]) else $error("tick too long");
   reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !wake_o && !alarm_irq_o
      && !overflow_irq_o && !second_tick_o && dat_o == '0) else $error("outputs not quiet after reset");
endmodule // rtc_counter_chk

bind rtc_counter_top rtc_counter_chk u_rtc_counter_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .xtal_i(xtal_i), .alarm_irq_o(alarm_irq_o), .overflow_irq_o(overflow_irq_o), .wake_o(wake_o),
   .irq_o(irq_o), .second_tick_o(second_tick_o));

// ---- bench/rtc_counter_with_alarms_tb_top.sv ----
// Self-checking bench: register table, lock, alarms, overflow, masks and flag clears.
// Assumes one wait state per bus request and a slow crystal pin driven by the bench.
`timescale 1ns/10ps
module rtc_counter_with_alarms_tb_top;
   import rtc_pkg::*;
   typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} rtc_row_t;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, xtal_i;
   logic alarm_irq_o, overflow_irq_o, wake_o, irq_o, second_tick_o;
   logic [31:0] adr_i, dat_i, dat_o, q;
   logic [3:0] sel_i;
   int miscompares = 0;
   int checked = 0;
   rtc_row_t rows [8] = '{'{1'b0, RTC_CONTROL_STATUS_ADR, 32'h0, 32'h1D}, '{1'b0, RTC_RUNNING_COUNT_ADR, 32'h0, 32'h0},
      '{1'b1, RTC_FIRST_ALARM_ADR, 32'hFFFF_FFFF, 32'h3_FFFF}, '{1'b1, RTC_SECOND_ALARM_ADR, 32'h1_2345, 32'h1_2345},
      '{1'b1, RTC_RUNNING_COUNT_ADR, 32'hFFFC_0005, 32'h5}, '{1'b1, 32'h0500_0070, 32'hAA, 32'h0},
      '{1'b0, RTC_EVENT_ENABLE_ADR, 32'h0, 32'h0}, '{1'b1, RTC_EVENT_CLEAR_ADR, 32'h3, 32'h0}};
   rtc_counter_top u_rtc_counter_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .xtal_i(xtal_i),
      .alarm_irq_o(alarm_irq_o), .overflow_irq_o(overflow_irq_o), .wake_o(wake_o), .irq_o(irq_o),
      .second_tick_o(second_tick_o));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic stop_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t pin %b expected %b", $time, got, exp);
      end
   endtask
   // Request held until ack is sampled and released at that same edge, so cyc always drops for a cycle
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         miscompares++;
         stop_test();
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk_word(q, e);
   endtask
   // Two crystal rising edges per counter step; 8 system clocks per crystal period keeps the sync happy
   task automatic step(input int n);
      repeat (2 * n) begin
         repeat (4) @(posedge clk_i);
         xtal_i <= 1'b1;
         repeat (4) @(posedge clk_i);
         xtal_i <= 1'b0;
      end
      repeat (6) @(posedge clk_i);
   endtask
   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      xtal_i = 1'b0;
      adr_i = 32'h0;
      dat_i = 32'h0;
      sel_i = 4'hF;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w)
            wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      wr(RTC_CONTROL_STATUS_ADR, 32'h0F);
      rd(RTC_CONTROL_STATUS_ADR, 32'h1F);
      wr(RTC_FIRST_ALARM_ADR, 32'h10);
      rd(RTC_FIRST_ALARM_ADR, 32'h3_FFFF);
      wr(RTC_CONTROL_STATUS_ADR, 32'h0D);
      wr(RTC_FIRST_ALARM_ADR, 32'h10);
      rd(RTC_FIRST_ALARM_ADR, 32'h10);
      // Configuration runs while the crystal pin is idle, far inside half a tick
      wr(RTC_SECOND_ALARM_ADR, 32'h0F);
      wr(RTC_RUNNING_COUNT_ADR, 32'h0E);
      wr(RTC_EVENT_ENABLE_ADR, 32'h7);
      step(2);
      rd(RTC_RUNNING_COUNT_ADR, 32'h10);
      rd(RTC_CONTROL_STATUS_ADR, 32'h7D);
      chk_bit(alarm_irq_o, 1'b1);
      chk_bit(wake_o, 1'b1);
      chk_bit(overflow_irq_o, 1'b0);
      rd(RTC_EVENT_STATUS_ADR, 32'h3);
      chk_bit(irq_o, 1'b1);
      wr(RTC_CONTROL_STATUS_ADR, 32'h05);
      repeat (3) @(posedge clk_i);
      chk_bit(alarm_irq_o, 1'b0);
      rd(RTC_CONTROL_STATUS_ADR, 32'h75);
      sel_i <= 4'h2;
      wr(RTC_CONTROL_STATUS_ADR, 32'hFF);
      sel_i <= 4'hF;
      rd(RTC_CONTROL_STATUS_ADR, 32'h75);
      wr(RTC_CONTROL_STATUS_ADR, 32'h6D);
      rd(RTC_CONTROL_STATUS_ADR, 32'h1D);
      chk_bit(alarm_irq_o, 1'b0);
      wr(RTC_EVENT_CLEAR_ADR, 32'h3);
      rd(RTC_EVENT_STATUS_ADR, 32'h0);
      chk_bit(irq_o, 1'b0);
      sel_i <= 4'h2;
      wr(RTC_FIRST_ALARM_ADR, 32'hFFFF_FFFF);
      sel_i <= 4'hF;
      rd(RTC_FIRST_ALARM_ADR, 32'hFF10);
      wr(RTC_RUNNING_COUNT_ADR, 32'h3_FFFF);
      step(1);
      rd(RTC_RUNNING_COUNT_ADR, 32'h0);
      rd(RTC_CONTROL_STATUS_ADR, 32'h0D);
      chk_bit(overflow_irq_o, 1'b1);
      chk_bit(wake_o, 1'b1);
      chk_bit(irq_o, 1'b1);
      wr(RTC_CONTROL_STATUS_ADR, 32'h09);
      repeat (3) @(posedge clk_i);
      chk_bit(overflow_irq_o, 1'b0);
      chk_bit(wake_o, 1'b0);
      wr(RTC_CONTROL_STATUS_ADR, 32'h1C);
      rd(RTC_CONTROL_STATUS_ADR, 32'h1C);
      step(2);
      rd(RTC_RUNNING_COUNT_ADR, 32'h0);
      wr(RTC_CONTROL_STATUS_ADR, 32'h0D);
      step(1);
      rd(RTC_RUNNING_COUNT_ADR, 32'h1);
      chk_bit(second_tick_o, 1'b0);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(RTC_CONTROL_STATUS_ADR, 32'h1D);
      rd(RTC_FIRST_ALARM_ADR, 32'h0);
      stop_test();
   end
endmodule // rtc_counter_with_alarms_tb_top
